// ### hdl/sdl_pkg.sv
// Purpose: shared constants and types for the sigma-delta loop control block
// Assumes: 200 MHz core_clk acts as the 4x symbol-rate sample clock
// Notes: register map uses word indices on the plain register port
package sdl_pkg;

	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 16;
	localparam int SAMPLE_W  = 10;
	localparam int ACC_W     = 16;

	// Register indices
	localparam logic [5:0] REG_CTRL        = 6'h00;
	localparam logic [5:0] REG_TIM_BW      = 6'h01;
	localparam logic [5:0] REG_GAIN_BW     = 6'h02;
	localparam logic [5:0] REG_CAR_BW      = 6'h03;
	localparam logic [5:0] REG_TIM_RATE    = 6'h04;
	localparam logic [5:0] REG_GAIN_RATE   = 6'h05;
	localparam logic [5:0] REG_CAR_RATE    = 6'h06;
	localparam logic [5:0] REG_TIM_SDRATE  = 6'h07;
	localparam logic [5:0] REG_GAIN_SDRATE = 6'h08;
	localparam logic [5:0] REG_CAR_SDRATE  = 6'h09;
	localparam logic [5:0] REG_OSC_PRESET  = 6'h0a;
	localparam logic [5:0] REG_OSC_UPPER   = 6'h0b;
	localparam logic [5:0] REG_OSC_LOWER   = 6'h0c;
	localparam logic [5:0] REG_TIM_THRESH  = 6'h0d;
	localparam logic [5:0] REG_CAR_THRESH  = 6'h0e;
	localparam logic [5:0] REG_ERR_THRESH  = 6'h0f;
	localparam logic [5:0] REG_CTAP_GAIN   = 6'h10;
	localparam logic [5:0] REG_LPF_COEF    = 6'h11;
	localparam logic [5:0] REG_EQ_TAP      = 6'h12;
	localparam logic [5:0] REG_STAT_OSC    = 6'h20;
	localparam logic [5:0] REG_STAT_GAIN   = 6'h21;
	localparam logic [5:0] REG_STAT_VAR    = 6'h22;
	localparam logic [5:0] REG_STAT_TIM    = 6'h23;
	localparam logic [5:0] REG_STAT_LOCK   = 6'h24;
	localparam logic [5:0] REG_STAT_STRAP  = 6'h25;

	// Control register fields
	localparam int CTRL_EQMODE_LSB = 0;
	localparam int CTRL_SWRST_BIT  = 2;

	// Reset values
	localparam logic [15:0] RST_BW      = 16'h0010;
	localparam logic [15:0] RST_RATE    = 16'h0000;
	localparam logic [15:0] RST_PRESET  = 16'h0000;
	localparam logic [15:0] RST_UPPER   = 16'h7fff;
	localparam logic [15:0] RST_LOWER   = 16'h8000;
	localparam logic [15:0] RST_THRESH  = 16'h0100;
	localparam logic [15:0] RST_CTAP    = 16'h4000;
	localparam logic [15:0] RST_ZERO    = 16'h0000;
	localparam int          LOCK_COUNT  = 16;

	typedef enum {EqLoadAdapt, EqLoadFreeze, EqAdapt, EqFreeze} eqMode_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] inPhase;
		logic [SAMPLE_W-1:0] quad;
	} sample_t;

	typedef struct packed {
		logic channelSwap;
		logic sampleFormat;
		logic symbolEdge;
		logic testBypass;
	} straps_t;

	typedef struct packed {
		logic [DATA_W-1:0] bandwidth;
		logic [DATA_W-1:0] loopRate;
		logic [DATA_W-1:0] sdRate;
	} loopCfg_t;

	// Signed saturating add used by every loop integrator
	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15])
			sat_add = s[16] ? 16'h8000 : 16'h7fff;
		else
			sat_add = s[15:0];
	endfunction

endpackage

// ### hdl/rate_divider.sv
// Purpose: programmable tick generator for loop and converter update rates
// Assumes: divide value 0 gives a tick every cycle (full 4x rate)
// Notes: tick is one cycle wide
`timescale 1ns/1ps
module rate_divider import sdl_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] divide,
	output logic              tick
);
	logic [W-1:0] count_q;
	wire          wrap = (count_q >= divide);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_q <= '0;
		end else if (clkEn) begin
			count_q <= wrap ? '0 : count_q + 1'b1;
		end
	end

	assign tick = clkEn & wrap;
endmodule

// ### hdl/sigma_delta_mod.sv
// Purpose: first-order digital sigma-delta converter to one output bit
// Assumes: signed two's complement input word
// Notes: bit held between update ticks
`timescale 1ns/1ps
module sigma_delta_mod import sdl_pkg::*; #(
	parameter int W = ACC_W
) (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic         clkEn,
	input  wire logic         update,
	input  wire logic [W-1:0] level,
	output logic              bitOut
);
	logic [W-1:0] acc_q;
	// Offset to unsigned so the carry is the density of the level
	wire  [W:0]   sum = {1'b0, acc_q} + {1'b0, ~level[W-1], level[W-2:0]};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			acc_q  <= '0;
			bitOut <= 1'b0;
		end else if (clkEn && update) begin
			acc_q  <= sum[W-1:0];
			bitOut <= sum[W];
		end
	end
endmodule

// ### hdl/sigma_delta_loop_control.sv
// Purpose: loop-control side of the demodulator: three one-bit loop outputs,
//          straps, host registers, status values and lock indicators
// Assumes: core_clk is the 4x symbol-rate sample clock; straps static
// Notes: loop error inputs come from the demodulator datapath
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module sigma_delta_loop_control import sdl_pkg::*; #(
	parameter int LOCK_CNT = LOCK_COUNT
) (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                clkEn,
	input  wire logic                power_on_reset_n,
	// Straps and converter samples (off-domain, synchronised)
	input  wire straps_t             strapPins,
	input  wire sample_t             sampleIn,
	// Loop errors and metrics from the datapath
	input  wire logic [DATA_W-1:0]   timingError,
	input  wire logic [DATA_W-1:0]   gainError,
	input  wire logic [DATA_W-1:0]   carrierError,
	input  wire logic [DATA_W-1:0]   varianceIn,
	input  wire logic [DATA_W-1:0]   symbolErrorIn,
	input  wire logic                eqLockIn,
	// Register port
	input  wire logic [ADDR_W-1:0]   regAddr,
	input  wire logic [DATA_W-1:0]   regWrData,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	output logic      [DATA_W-1:0]   regRdData,
	// Outputs
	output logic                     timing_loop_bit_out,
	output logic                     gain_loop_bit_out,
	output logic                     carrier_loop_bit_out,
	output logic                     converter_clock_out,
	output logic                     symbol_edge_select_pin,
	output logic                     demod_lock_out,
	output logic                     timing_lock_out,
	output sample_t                  sampleOut,
	output logic                     bypassOut,
	output logic      [1:0]          eqModeOut
);
	// ------------------------------------------------------------------
	// Reset: pin, software reset bit, and sync reset merged
	// ------------------------------------------------------------------
	logic porMeta_q, porSync_q, swReset_q;
	logic [3:0] strapMeta_q, strapSync_q;
	sample_t sampleMeta_q, sampleSync_q;
	wire  fullReset = srst | ~porSync_q | swReset_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			porMeta_q <= 1'b0;
			porSync_q <= 1'b0;
		end else if (clkEn) begin
			porMeta_q <= power_on_reset_n;
			porSync_q <= porMeta_q;
		end
	end

	// ------------------------------------------------------------------
	// Strap and sample synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strapMeta_q  <= '0;
			strapSync_q  <= '0;
			sampleMeta_q <= '0;
			sampleSync_q <= '0;
		end else if (clkEn) begin
			strapMeta_q  <= strapPins;
			strapSync_q  <= strapMeta_q;
			sampleMeta_q <= sampleIn;
			sampleSync_q <= sampleMeta_q;
		end
	end

	straps_t straps;
	assign straps = strapSync_q;

	// Offset binary becomes two's complement by flipping the sign bit
	wire [SAMPLE_W-1:0] iConv = straps.sampleFormat ?
		{~sampleSync_q.inPhase[SAMPLE_W-1], sampleSync_q.inPhase[SAMPLE_W-2:0]} : sampleSync_q.inPhase;
	wire [SAMPLE_W-1:0] qConv = straps.sampleFormat ?
		{~sampleSync_q.quad[SAMPLE_W-1], sampleSync_q.quad[SAMPLE_W-2:0]} : sampleSync_q.quad;
	sample_t sampleRouted;
	assign sampleRouted.inPhase = straps.channelSwap ? qConv : iConv;
	assign sampleRouted.quad    = straps.channelSwap ? iConv : qConv;

	// ------------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------------
	loopCfg_t timCfg_q, gainCfg_q, carCfg_q;
	logic [DATA_W-1:0] oscPreset_q, oscUpper_q, oscLower_q;
	logic [DATA_W-1:0] timThresh_q, carThresh_q, errThresh_q;
	logic [DATA_W-1:0] ctapGain_q, lpfCoef_q, eqTap_q;
	logic [1:0]        eqMode_q;

	wire wrEn = clkEn & regWrite;

	always_ff @(posedge core_clk) begin
		if (fullReset) begin
			timCfg_q    <= '{RST_BW, RST_RATE, RST_RATE};
			gainCfg_q   <= '{RST_BW, RST_RATE, RST_RATE};
			carCfg_q    <= '{RST_BW, RST_RATE, RST_RATE};
			oscPreset_q <= RST_PRESET;
			oscUpper_q  <= RST_UPPER;
			oscLower_q  <= RST_LOWER;
			timThresh_q <= RST_THRESH;
			carThresh_q <= RST_THRESH;
			errThresh_q <= RST_THRESH;
			ctapGain_q  <= RST_CTAP;
			lpfCoef_q   <= RST_ZERO;
			eqTap_q     <= RST_ZERO;
			eqMode_q    <= 2'(EqLoadAdapt);
		end else if (wrEn) begin
			case (regAddr)
				REG_CTRL:        eqMode_q              <= regWrData[CTRL_EQMODE_LSB +: 2];
				REG_TIM_BW:      timCfg_q.bandwidth    <= regWrData;
				REG_GAIN_BW:     gainCfg_q.bandwidth   <= regWrData;
				REG_CAR_BW:      carCfg_q.bandwidth    <= regWrData;
				REG_TIM_RATE:    timCfg_q.loopRate     <= regWrData;
				REG_GAIN_RATE:   gainCfg_q.loopRate    <= regWrData;
				REG_CAR_RATE:    carCfg_q.loopRate     <= regWrData;
				REG_TIM_SDRATE:  timCfg_q.sdRate       <= regWrData;
				REG_GAIN_SDRATE: gainCfg_q.sdRate      <= regWrData;
				REG_CAR_SDRATE:  carCfg_q.sdRate       <= regWrData;
				REG_OSC_PRESET:  oscPreset_q           <= regWrData;
				REG_OSC_UPPER:   oscUpper_q            <= regWrData;
				REG_OSC_LOWER:   oscLower_q            <= regWrData;
				REG_TIM_THRESH:  timThresh_q           <= regWrData;
				REG_CAR_THRESH:  carThresh_q           <= regWrData;
				REG_ERR_THRESH:  errThresh_q           <= regWrData;
				REG_CTAP_GAIN:   ctapGain_q            <= regWrData;
				REG_LPF_COEF:    lpfCoef_q             <= regWrData;
				REG_EQ_TAP:      eqTap_q               <= regWrData;
				default: ;
			endcase
		end
	end

	// Software reset self-clears after one cycle of full reset
	always_ff @(posedge core_clk) begin
		if (srst || swReset_q) begin
			swReset_q <= 1'b0;
		end else if (wrEn && regAddr == REG_CTRL) begin
			swReset_q <= regWrData[CTRL_SWRST_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Loop integrators with per-loop bandwidth shift and rate
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] timInt_q, gainInt_q, oscFreq_q;
	logic timTick, gainTick, carTick, timSdTick, gainSdTick, carSdTick;

	rate_divider u_timRate  (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(timCfg_q.loopRate), .tick(timTick));
	rate_divider u_gainRate (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(gainCfg_q.loopRate), .tick(gainTick));
	rate_divider u_carRate  (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(carCfg_q.loopRate), .tick(carTick));
	rate_divider u_timSd    (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(timCfg_q.sdRate), .tick(timSdTick));
	rate_divider u_gainSd   (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(gainCfg_q.sdRate), .tick(gainSdTick));
	rate_divider u_carSd    (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.divide(carCfg_q.sdRate), .tick(carSdTick));

	// Bandwidth is a right-shift of the error; low 4 bits used
	wire [DATA_W-1:0] timStep  = DATA_W'($signed(timingError)  >>> timCfg_q.bandwidth[3:0]);
	wire [DATA_W-1:0] gainStep = DATA_W'($signed(gainError)    >>> gainCfg_q.bandwidth[3:0]);
	wire [DATA_W-1:0] carStep  = DATA_W'($signed(carrierError) >>> carCfg_q.bandwidth[3:0]);
	wire [DATA_W-1:0] oscSum   = sat_add(oscFreq_q, carStep);
	// Clamp keeps the oscillator inside the host window during tracking
	wire [DATA_W-1:0] oscNext  = ($signed(oscSum) > $signed(oscUpper_q)) ? oscUpper_q :
		(($signed(oscSum) < $signed(oscLower_q)) ? oscLower_q : oscSum);
	wire oscHold = (eqMode_q == 2'(EqFreeze)) & straps.testBypass;

	always_ff @(posedge core_clk) begin
		if (fullReset) begin
			timInt_q  <= RST_ZERO;
			gainInt_q <= RST_ZERO;
			oscFreq_q <= RST_PRESET;
		end else if (clkEn) begin
			if (timTick)
				timInt_q <= sat_add(timInt_q, timStep);
			if (gainTick)
				gainInt_q <= sat_add(gainInt_q, gainStep);
			if (wrEn && regAddr == REG_OSC_PRESET)
				oscFreq_q <= regWrData;
			else if (carTick && !oscHold)
				oscFreq_q <= oscNext;
		end
	end

	sigma_delta_mod u_timSdm (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.update(timSdTick), .level(timInt_q), .bitOut(timing_loop_bit_out));
	sigma_delta_mod u_gainSdm (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.update(gainSdTick), .level(gainInt_q), .bitOut(gain_loop_bit_out));
	sigma_delta_mod u_carSdm (.core_clk(core_clk), .srst(fullReset), .clkEn(clkEn),
		.update(carSdTick), .level(oscFreq_q), .bitOut(carrier_loop_bit_out));

	// ------------------------------------------------------------------
	// Lock detection
	// ------------------------------------------------------------------
	function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v);
		magnitude = v[DATA_W-1] ? DATA_W'(-v) : v;
	endfunction

	wire carLockNow = varianceIn < carThresh_q;
	wire timLockNow = magnitude(timInt_q) < timThresh_q;
	wire errLowNow  = symbolErrorIn < errThresh_q;
	logic [7:0] errCount_q;
	wire errSteady  = errCount_q >= 8'(LOCK_CNT);

	always_ff @(posedge core_clk) begin
		if (fullReset) begin
			errCount_q <= '0;
		end else if (clkEn) begin
			if (!errLowNow)
				errCount_q <= '0;
			else if (!errSteady)
				errCount_q <= errCount_q + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (fullReset) begin
			converter_clock_out    <= 1'b0;
			symbol_edge_select_pin <= 1'b0;
			demod_lock_out         <= 1'b0;
			timing_lock_out        <= 1'b0;
			sampleOut              <= '0;
			bypassOut              <= 1'b0;
			eqModeOut              <= 2'(EqLoadAdapt);
		end else if (clkEn) begin
			converter_clock_out    <= ~converter_clock_out;
			symbol_edge_select_pin <= straps.symbolEdge;
			demod_lock_out         <= carLockNow & eqLockIn & errSteady;
			timing_lock_out        <= timLockNow;
			sampleOut              <= sampleRouted;
			bypassOut              <= straps.testBypass;
			eqModeOut              <= eqMode_q;
		end
	end

	// ------------------------------------------------------------------
	// Read path: data one cycle after the read strobe
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] rdMux;
	always_comb begin
		case (regAddr)
			REG_CTRL:        rdMux = {14'h0000, eqMode_q};
			REG_TIM_BW:      rdMux = timCfg_q.bandwidth;
			REG_GAIN_BW:     rdMux = gainCfg_q.bandwidth;
			REG_CAR_BW:      rdMux = carCfg_q.bandwidth;
			REG_TIM_RATE:    rdMux = timCfg_q.loopRate;
			REG_GAIN_RATE:   rdMux = gainCfg_q.loopRate;
			REG_CAR_RATE:    rdMux = carCfg_q.loopRate;
			REG_TIM_SDRATE:  rdMux = timCfg_q.sdRate;
			REG_GAIN_SDRATE: rdMux = gainCfg_q.sdRate;
			REG_CAR_SDRATE:  rdMux = carCfg_q.sdRate;
			REG_OSC_PRESET:  rdMux = oscPreset_q;
			REG_OSC_UPPER:   rdMux = oscUpper_q;
			REG_OSC_LOWER:   rdMux = oscLower_q;
			REG_TIM_THRESH:  rdMux = timThresh_q;
			REG_CAR_THRESH:  rdMux = carThresh_q;
			REG_ERR_THRESH:  rdMux = errThresh_q;
			REG_CTAP_GAIN:   rdMux = ctapGain_q;
			REG_LPF_COEF:    rdMux = lpfCoef_q;
			REG_EQ_TAP:      rdMux = eqTap_q;
			REG_STAT_OSC:    rdMux = oscFreq_q;
			REG_STAT_GAIN:   rdMux = gainInt_q;
			REG_STAT_VAR:    rdMux = varianceIn;
			REG_STAT_TIM:    rdMux = timInt_q;
			REG_STAT_LOCK:   rdMux = {13'h0000, errSteady, timLockNow, carLockNow};
			REG_STAT_STRAP:  rdMux = {12'h000, straps};
			default:         rdMux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (fullReset) begin
			regRdData <= '0;
		end else if (clkEn) begin
			regRdData <= regRead ? rdMux : 16'h0000;
		end
	end
endmodule

// ### tb/sdl_props.sv
// Purpose: port-level properties of sigma_delta_loop_control
// Assumes: bench keeps clkEn high around register writes
// Notes: a short history masks the reset pipelines
`timescale 1ns/1ps
module sdl_props import sdl_pkg::*; (
	input wire logic              core_clk,
	input wire logic              srst,
	input wire logic              clkEn,
	input wire logic              power_on_reset_n,
	input wire straps_t           strapPins,
	input wire logic              eqLockIn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic              converter_clock_out,
	input wire logic              symbol_edge_select_pin,
	input wire logic              demod_lock_out,
	input wire logic              timing_lock_out,
	input wire logic              bypassOut,
	input wire logic [1:0]        eqModeOut
);
	// ----------------------------------------
	// Reset history
	// ----------------------------------------
	logic [5:0] rstHist_q;
	wire        swRst = regWrite && regAddr == REG_CTRL && regWrData[CTRL_SWRST_BIT];
	wire        quiet = srst || !power_on_reset_n || |rstHist_q;
	// Por and soft reset act through pipelines, so mute checks a while
	always_ff @(posedge core_clk) begin
		rstHist_q <= {rstHist_q[4:0], srst || !power_on_reset_n || swRst};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (quiet);
	sequence ctrlWrite;
		regWrite && clkEn && regAddr == REG_CTRL && !regWrData[CTRL_SWRST_BIT];
	endsequence
	sequence softReset;
		regWrite && clkEn && swRst;
	endsequence
	a_rd_idle_zero: assert property ($past(clkEn) && !$past(regRead) |-> regRdData == '0)
		else $error("read data not zero outside read slot");
	a_unmapped_read: assert property (regRead && clkEn && regAddr == 6'h3f |=> regRdData == '0)
		else $error("unmapped read returned data");
	a_conv_clk_toggle: assert property (clkEn |=> converter_clock_out != $past(converter_clock_out))
		else $error("converter clock did not toggle");
	a_edge_pin_follow: assert property ((clkEn && $stable(strapPins))[*5] |-> symbol_edge_select_pin == strapPins.symbolEdge)
		else $error("edge select pin differs from strap");
	a_bypass_follow: assert property ((clkEn && $stable(strapPins))[*5] |-> bypassOut == strapPins.testBypass)
		else $error("bypass output differs from strap");
	a_eq_mode_write: assert property (ctrlWrite ##1 (!regWrite && clkEn) |=> eqModeOut == $past(regWrData[1:0], 2))
		else $error("equalizer mode not taken from control write");
	a_soft_reset_clears: assert property (disable iff (srst || !power_on_reset_n)
		softReset |-> ##2 (eqModeOut == 2'h0 && !demod_lock_out && !timing_lock_out && !converter_clock_out))
		else $error("soft reset left outputs set");
	a_demod_needs_eq: assert property (demod_lock_out |-> $past(eqLockIn))
		else $error("demod lock without equalizer lock");
endmodule
bind sigma_delta_loop_control sdl_props u_sdl_props (.core_clk(core_clk), .srst(srst), .clkEn(clkEn),
	.power_on_reset_n(power_on_reset_n), .strapPins(strapPins), .eqLockIn(eqLockIn), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.converter_clock_out(converter_clock_out), .symbol_edge_select_pin(symbol_edge_select_pin),
	.demod_lock_out(demod_lock_out), .timing_lock_out(timing_lock_out), .bypassOut(bypassOut),
	.eqModeOut(eqModeOut));

// ### tb/loop_analog_model.sv
// Purpose: external analog loop filters seen as bit-density counters
// Assumes: clear held high outside a measuring window
// Notes: counters wrap past 255, so windows stay short
`timescale 1ns/1ps
module loop_analog_model (
	input  wire logic       core_clk,
	input  wire logic       clear,
	input  wire logic [2:0] loopBits,
	output logic [2:0][7:0] ones,
	output logic [7:0]      flips
);
	logic lastBit_q;
	// Density stands in for the analog integrator voltage
	always_ff @(posedge core_clk) begin
		lastBit_q <= loopBits[0];
		if (clear) begin
			ones <= '0;
			flips <= '0;
		end else begin
			for (int k = 0; k < 3; k++) ones[k] <= ones[k] + 8'(loopBits[k]);
			flips <= flips + 8'(loopBits[0] != lastBit_q);
		end
	end
endmodule

// ### tb/sigma_delta_loop_control_tb_top.sv
// Purpose: self-checking bench for sigma_delta_loop_control
// Assumes: LOCK_CNT shortened to 4
// Notes: every task returns on a rising edge
`timescale 1ns/1ps
module sigma_delta_loop_control_tb_top import sdl_pkg::*;;
	localparam int LCNT = 4;
	logic              core_clk = 1'b0;
	logic              srst = 1'b1;
	logic              clkEn = 1'b1;
	logic              porN = 1'b1;
	straps_t           strapPins = '0;
	sample_t           sampleIn = '0;
	logic [DATA_W-1:0] loopErr = '0;
	logic [DATA_W-1:0] varianceIn = '0;
	logic [DATA_W-1:0] symErr = '0;
	logic              eqLockIn = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	logic              mClear = 1'b1;
	logic [DATA_W-1:0] regRdData;
	logic              tBit, gBit, cBit, convClk, edgePin, dLock, tLock, bypassOut;
	sample_t           sampleOut;
	logic [1:0]        eqModeOut;
	logic [2:0][7:0]   ones;
	logic [7:0]        flips;
	int                n_mismatch = 0;
	int                tests_run = 0;
	int                cycles = 0;
	always #2.5 core_clk = ~core_clk;
	sigma_delta_loop_control #(.LOCK_CNT(LCNT)) u_sigma_delta_loop_control (
		.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .power_on_reset_n(porN), .strapPins(strapPins),
		.sampleIn(sampleIn), .timingError(loopErr), .gainError(loopErr), .carrierError(loopErr),
		.varianceIn(varianceIn), .symbolErrorIn(symErr), .eqLockIn(eqLockIn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.timing_loop_bit_out(tBit), .gain_loop_bit_out(gBit), .carrier_loop_bit_out(cBit),
		.converter_clock_out(convClk), .symbol_edge_select_pin(edgePin), .demod_lock_out(dLock),
		.timing_lock_out(tLock), .sampleOut(sampleOut), .bypassOut(bypassOut), .eqModeOut(eqModeOut));
	loop_analog_model u_loop_analog_model (.core_clk(core_clk), .clear(mClear), .loopBits({cBit, gBit, tBit}),
		.ones(ones), .flips(flips));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Extra idle edge keeps back-to-back calls from double-driving the strobe
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		tick(1);
		regWrite <= 1'b0;
		tick(1);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		tick(1);
		regRead <= 1'b0;
		tick(1);
		check(regRdData, exp);
	endtask
	task automatic measure();
		mClear <= 1'b0;
		tick(100);
		mClear <= 1'b1;
	endtask
	function automatic logic [15:0] rstVal(input logic [5:0] a);
		case (a)
			REG_TIM_BW, REG_GAIN_BW, REG_CAR_BW: return RST_BW;
			REG_OSC_UPPER: return RST_UPPER;
			REG_OSC_LOWER: return RST_LOWER;
			REG_TIM_THRESH, REG_CAR_THRESH, REG_ERR_THRESH: return RST_THRESH;
			REG_CTAP_GAIN: return RST_CTAP;
			default: return RST_ZERO;
		endcase
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int a = 1; a <= 18; a++) begin
			rdchk(6'(a), rstVal(6'(a)));
			wr(6'(a), 16'h5a00 | 16'(a));
			rdchk(6'(a), 16'h5a00 | 16'(a));
		end
		rdchk(6'h3f, 16'h0000);
	endtask
	task automatic t_reset();
		wr(REG_TIM_BW, 16'h0003);
		wr(REG_CTRL, 16'h0004);
		tick(2);
		rdchk(REG_TIM_BW, RST_BW);
		rdchk(REG_CTRL, 16'h0000);
		wr(REG_CAR_BW, 16'h0007);
		porN <= 1'b0;
		tick(4);
		porN <= 1'b1;
		tick(5);
		rdchk(REG_CAR_BW, RST_BW);
	endtask
	task automatic t_straps();
		sample_t exp;
		sampleIn <= {10'h2a5, 10'h13c};
		for (int s = 0; s < 16; s++) begin
			strapPins <= straps_t'(4'(s));
			tick(6);
			exp.inPhase = (s[3] ? 10'h13c : 10'h2a5) ^ {s[2], 9'h000};
			exp.quad = (s[3] ? 10'h2a5 : 10'h13c) ^ {s[2], 9'h000};
			check(16'(sampleOut.inPhase), 16'(exp.inPhase));
			check(16'(sampleOut.quad), 16'(exp.quad));
			check(16'(edgePin), 16'(s[1]));
			check(16'(bypassOut), 16'(s[0]));
		end
		strapPins <= '0;
	endtask
	task automatic t_eq();
		logic c;
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, 16'(m));
			tick(1);
			check(16'(eqModeOut), 16'(m));
		end
		clkEn <= 1'b0;
		tick(1);
		c = convClk;
		tick(3);
		check(16'(convClk), 16'(c));
		clkEn <= 1'b1;
		tick(1);
	endtask
	task automatic t_sd();
		int hi [3];
		loopErr <= 16'h0400;
		tick(300);
		measure();
		for (int k = 0; k < 3; k++) hi[k] = ones[k];
		loopErr <= 16'hfc00;
		tick(300);
		measure();
		for (int k = 0; k < 3; k++) check(16'(hi[k] > ones[k] + 60 || ones[k] > hi[k] + 60), 16'h0001);
		wr(REG_TIM_SDRATE, 16'h0003);
		loopErr <= 16'h0400;
		tick(32);
		loopErr <= 16'h0000;
		measure();
		check(16'(flips <= 8'd26), 16'h0001);
	endtask
	task automatic t_locks();
		wr(REG_CTRL, 16'h0004);
		tick(2);
		varianceIn <= 16'h0010;
		symErr <= 16'h0010;
		eqLockIn <= 1'b1;
		tick(LCNT + 4);
		check(16'(dLock), 16'h0001);
		check(16'(tLock), 16'h0001);
		rdchk(REG_STAT_LOCK, 16'h0007);
		rdchk(REG_STAT_VAR, 16'h0010);
		wr(REG_STAT_VAR, 16'h0000);
		rdchk(REG_STAT_VAR, 16'h0010);
		rdchk(REG_STAT_TIM, RST_ZERO);
		rdchk(REG_STAT_GAIN, RST_ZERO);
		wr(REG_OSC_PRESET, 16'h0123);
		rdchk(REG_STAT_OSC, 16'h0123);
		varianceIn <= 16'h0200;
		tick(3);
		check(16'(dLock), 16'h0000);
		varianceIn <= 16'h0010;
		tick(LCNT + 4);
		eqLockIn <= 1'b0;
		tick(3);
		check(16'(dLock), 16'h0000);
		eqLockIn <= 1'b1;
		tick(LCNT + 4);
		symErr <= 16'h0200;
		tick(1);
		symErr <= 16'h0010;
		tick(2);
		check(16'(dLock), 16'h0000);
		tick(LCNT + 4);
		check(16'(dLock), 16'h0001);
		wr(REG_TIM_THRESH, 16'h0000);
		tick(2);
		check(16'(tLock), 16'h0000);
		wr(REG_OSC_UPPER, 16'h0300);
		loopErr <= 16'h0100;
		tick(8);
		rdchk(REG_STAT_OSC, 16'h0300);
		wr(REG_CTRL, 16'h0003);
		strapPins <= straps_t'(4'h1);
		tick(4);
		loopErr <= 16'hff00;
		tick(8);
		rdchk(REG_STAT_OSC, 16'h0300);
	endtask
	initial begin
		tick(6);
		srst <= 1'b0;
		tick(3);
		t_regs();
		t_reset();
		t_straps();
		t_eq();
		t_sd();
		t_locks();
		finish_test();
	end
	// Whole run needs about 1300 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
endmodule
